// file: hdl/flash_host.sv
// Host controller that runs read, signature, program, erase and reset on the flash.
`timescale 1ns/100ps
// Notes on behaviour
// - Each command goes out in one or two consecutive write cycles, chosen by the first byte.
// - After a program or erase write the host waits at least 6 us before a read.
// - A write may follow a read with no recovery delay.
// - The host retries program and verify for a byte at most 25 times.
// - Before a chip erase the host programs every byte to 00H.
// - 00H selects array read; 90H selects signature reads at addresses 0 and 1.
// - Erase is 20H twice; program is 40H then a write of address and data.
// - C0H enters program verify; A0H enters erase verify and latches the address.
module flash_host #(
  parameter int ERASE_PULSE_CYC = flash_host_pkg::ERASE_CYC,
  parameter int PROG_LIMIT = flash_host_pkg::PROG_TRIES,
  parameter int ERASE_LIMIT = flash_host_pkg::ERASE_TRIES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire flash_host_pkg::host_cmd_t cmd,
  output logic rsp_valid,
  output flash_host_pkg::host_rsp_t rsp,
  output flash_host_pkg::flash_pins_t pins,
  input wire logic [7:0] dq_in,
  output logic vpp_en
);

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  typedef enum logic [9:0] {
    M_IDLE = 10'b0000000001,
    M_VPP = 10'b0000000010,
    M_C1 = 10'b0000000100,
    M_C2 = 10'b0000001000,
    M_PULSE = 10'b0000010000,
    M_VCMD = 10'b0000100000,
    M_RECOV = 10'b0001000000,
    M_RD = 10'b0010000000,
    M_CHECK = 10'b0100000000,
    M_FIN = 10'b1000000000
  } mstate_t;

  localparam int AW = flash_host_pkg::ADDR_W;

  mstate_t state, next_state;
  flash_host_pkg::op_t op, next_op;
  logic [AW-1:0] addr, next_addr;
  logic [7:0] data, next_data;
  logic [9:0] tries, next_tries;
  logic [19:0] timer, next_timer;
  logic pre, next_pre;
  logic sent, next_sent;
  logic next_rsp_valid, next_vpp, done_pend, next_done_pend;
  flash_host_pkg::host_rsp_t next_rsp;
  flash_host_pkg::bus_req_t breq;
  logic issue, breq_valid, breq_ready, bus_done, erasing, pass;
  logic [7:0] rdata;
  logic [19:0] stay_cnt;

  // First command byte of each operation.
  function automatic logic [7:0] first_byte(input flash_host_pkg::op_t o, input logic p);
    unique case (o)
      flash_host_pkg::OP_READ: first_byte = flash_host_pkg::CMD_READ;
      flash_host_pkg::OP_SIG: first_byte = flash_host_pkg::CMD_SIG;
      flash_host_pkg::OP_ERASE: first_byte = p ? flash_host_pkg::CMD_PROG : flash_host_pkg::CMD_ERASE;
      flash_host_pkg::OP_RESET: first_byte = flash_host_pkg::CMD_RESET;
      default: first_byte = flash_host_pkg::CMD_PROG;
    endcase
  endfunction : first_byte

  assign cmd_ready = (state == M_IDLE);
  assign erasing = (op == flash_host_pkg::OP_ERASE) && !pre;
  assign breq_valid = issue && !sent;
  assign pass = (rdata == (erasing ? flash_host_pkg::ERASED_BYTE : data));

  flash_bus_cycle u_cycle (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .req_valid(breq_valid),
    .req(breq),
    .req_ready(breq_ready),
    .done(bus_done),
    .rdata(rdata),
    .pins(pins),
    .dq_in(dq_in)
  );

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  // Walks each operation through its write, pulse, verify and read steps.
  always_comb begin
    next_state = state;
    next_op = op;
    next_addr = addr;
    next_data = data;
    next_tries = tries;
    next_timer = timer;
    next_pre = pre;
    next_rsp_valid = 1'b0;
    next_rsp = rsp;
    next_vpp = vpp_en;
    next_done_pend = done_pend;
    issue = 1'b0;
    breq = '{1'b1, addr, flash_host_pkg::CMD_READ};
    unique case (state)
      M_IDLE: begin
        if (cmd_valid) begin
          next_op = cmd.op;
          next_pre = (cmd.op == flash_host_pkg::OP_ERASE);
          next_addr = next_pre ? '0 : cmd.addr;
          next_data = next_pre ? flash_host_pkg::PRECOND_BYTE : cmd.data;
          next_tries = 10'h000;
          next_vpp = 1'b1;
          next_timer = 20'(flash_host_pkg::VPP_CYC - 1);
          next_state = M_VPP;
        end
      end
      M_VPP: begin
        next_timer = timer - 20'h00001;
        if (timer == 20'h00000) begin
          next_state = M_C1;
        end
      end
      M_C1: begin
        issue = 1'b1;
        breq.data = first_byte(op, pre);
        if (bus_done) begin
          // Read and signature are one-write commands; the rest take two.
          if (op == flash_host_pkg::OP_READ || op == flash_host_pkg::OP_SIG) begin
            next_state = M_RD;
          end else begin
            next_state = M_C2;
          end
        end
      end
      M_C2: begin
        issue = 1'b1;
        if (op == flash_host_pkg::OP_RESET) begin
          breq.data = flash_host_pkg::CMD_RESET;
        end else if (erasing) begin
          breq.data = flash_host_pkg::CMD_ERASE;
        end else begin
          breq.data = data;
        end
        if (bus_done) begin
          if (op == flash_host_pkg::OP_RESET) begin
            next_rsp = '{1'b1, 8'h00};
            next_done_pend = 1'b1;
            next_state = M_FIN;
          end else begin
            next_timer = erasing ? 20'(ERASE_PULSE_CYC - 1)
                                 : 20'(flash_host_pkg::PROG_CYC - 1);
            next_state = M_PULSE;
          end
        end
      end
      M_PULSE: begin
        next_timer = timer - 20'h00001;
        if (timer == 20'h00000) begin
          next_state = M_VCMD;
        end
      end
      M_VCMD: begin
        issue = 1'b1;
        breq.data = erasing ? flash_host_pkg::CMD_ERASE_VFY
                            : flash_host_pkg::CMD_PROG_VFY;
        if (bus_done) begin
          next_timer = 20'(flash_host_pkg::RECOV_CYC - 1);
          next_state = M_RECOV;
        end
      end
      M_RECOV: begin
        next_timer = timer - 20'h00001;
        if (timer == 20'h00000) begin
          next_state = M_RD;
        end
      end
      M_RD: begin
        issue = 1'b1;
        breq.wr = 1'b0;
        if (op == flash_host_pkg::OP_SIG) begin
          breq.addr = {{(AW-1){1'b0}}, addr[0]};
        end
        if (bus_done) begin
          if (op == flash_host_pkg::OP_READ || op == flash_host_pkg::OP_SIG) begin
            next_rsp = '{1'b1, rdata};
            next_done_pend = 1'b1;
            next_state = M_FIN;
          end else begin
            next_state = M_CHECK;
          end
        end
      end
      M_CHECK: begin
        next_tries = tries + 10'h001;
        next_state = M_C1;
        if (pass && erasing) begin
          next_tries = tries;
          next_state = M_VCMD;
          next_addr = addr + 1'b1;
          if (&addr) begin
            next_rsp = '{1'b1, rdata};
            next_state = M_FIN;
          end
        end else if (pass) begin
          next_tries = 10'h000;
          next_addr = addr + 1'b1;
          if (op == flash_host_pkg::OP_PROG) begin
            next_rsp = '{1'b1, rdata};
            next_state = M_FIN;
          end else if (&addr) begin
            next_pre = 1'b0;
          end
        end else if (!erasing && tries == 10'(PROG_LIMIT - 1)) begin
          next_rsp = '{1'b0, rdata};
          next_state = M_FIN;
        end else if (erasing && tries == 10'(ERASE_LIMIT - 1)) begin
          next_rsp = '{1'b0, rdata};
          next_state = M_FIN;
        end
      end
      M_FIN: begin
        issue = !done_pend;
        breq.data = flash_host_pkg::CMD_READ;
        if (bus_done || done_pend) begin
          next_done_pend = 1'b0;
          next_rsp_valid = 1'b1;
          next_vpp = 1'b0;
          next_state = M_IDLE;
        end
      end
    endcase
    next_sent = (sent || (breq_valid && breq_ready)) && !bus_done;
  end

  // Registers the sequencer.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= M_IDLE;
      op <= flash_host_pkg::OP_READ;
      addr <= '0;
      data <= 8'h00;
      tries <= 10'h000;
      timer <= 20'h00000;
      pre <= 1'b0;
      sent <= 1'b0;
      rsp_valid <= 1'b0;
      rsp <= '0;
      vpp_en <= 1'b0;
      done_pend <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      addr <= next_addr;
      data <= next_data;
      tries <= next_tries;
      timer <= next_timer;
      pre <= next_pre;
      sent <= next_sent;
      rsp_valid <= next_rsp_valid;
      rsp <= next_rsp;
      vpp_en <= next_vpp;
      done_pend <= next_done_pend;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Counts cycles spent in the present state.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stay_cnt <= 20'h00000;
    end else begin
      stay_cnt <= (next_state != state) ? 20'h00000 : stay_cnt + 20'h00001;
    end
  end

  property p_prog_pulse;
    @(posedge clk_sys) disable iff (!resetn)
    (state == M_PULSE && next_state == M_VCMD && !erasing)
      |-> stay_cnt == 20'(flash_host_pkg::PROG_CYC - 1);
  endproperty
  a_prog_pulse: assert property (p_prog_pulse)
    else $error("Program pulse wait has the wrong length.");

  property p_recov;
    @(posedge clk_sys) disable iff (!resetn)
    (state == M_RECOV && next_state == M_RD)
      |-> stay_cnt == 20'(flash_host_pkg::RECOV_CYC - 1);
  endproperty
  a_recov: assert property (p_recov)
    else $error("Read issued before write recovery elapsed.");

  property p_tries;
    @(posedge clk_sys) disable iff (!resetn)
    (state == M_C1 && !erasing && op != flash_host_pkg::OP_RESET) |-> tries < 10'(PROG_LIMIT);
  endproperty
  a_tries: assert property (p_tries)
    else $error("Program retried too often.");

  property p_erase_after_pre;
    @(posedge clk_sys) disable iff (!resetn)
    (breq_valid && breq.wr && breq.data == flash_host_pkg::CMD_ERASE) |-> !pre;
  endproperty
  a_erase_after_pre: assert property (p_erase_after_pre)
    else $error("Erase command before preconditioning ended.");

  property p_read_byte;
    @(posedge clk_sys) disable iff (!resetn)
    (state == M_C1 && breq_valid && op == flash_host_pkg::OP_READ)
      |-> breq.wr && breq.data == 8'h00;
  endproperty
  a_read_byte: assert property (p_read_byte)
    else $error("Read mode command byte wrong.");

  sequence s_second_write;
    ##[1:40] (state == M_C2 && breq_valid && breq.data == 8'h20);
  endsequence

  property p_erase_twice;
    @(posedge clk_sys) disable iff (!resetn)
    (state == M_C1 && bus_done && erasing) |-> s_second_write;
  endproperty
  a_erase_twice: assert property (p_erase_twice)
    else $error("Erase not confirmed by a second 20H write.");

  property p_verify_byte;
    @(posedge clk_sys) disable iff (!resetn)
    (state == M_VCMD && breq_valid)
      |-> breq.data == (erasing ? 8'hA0 : 8'hC0) && breq.addr == addr;
  endproperty
  a_verify_byte: assert property (p_verify_byte)
    else $error("Verify command byte or address wrong.");

  property p_two_cycle;
    @(posedge clk_sys) disable iff (!resetn)
    (state == M_C1 && bus_done && op == flash_host_pkg::OP_RESET)
      |=> state == M_C2 ##[1:40] (bus_done && state == M_C2);
  endproperty
  a_two_cycle: assert property (p_two_cycle)
    else $error("Reset command not sent in two cycles.");

  property p_rsp_pulse;
    @(posedge clk_sys) disable iff (!resetn)
    rsp_valid |-> !vpp_en ##1 !rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse)
    else $error("Answer not a single pulse or supply left high.");

endmodule : flash_host

// file: shared/flash_host_pkg.sv
// Shared constants, timing figures and carrier types of the flash host controller.
package flash_host_pkg;

  // ----------------------------------------------------------------
  // Clock and bus timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int T_WP_NS = 40;
  localparam int T_WPH_NS = 20;
  localparam int T_ACC_NS = 150;
  localparam int T_VPP_NS = 100;
  localparam int T_PROG_US = 10;
  localparam int T_RECOV_US = 6;
  localparam int T_ERASE_US = 9500;
  localparam int SYNC_CYC = 2;

  // Least time in whole clock cycles, never below one.
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    cyc_min = (c < 1) ? 1 : c;
  endfunction : cyc_min

  localparam int WP_CYC = cyc_min(T_WP_NS);
  localparam int WPH_CYC = cyc_min(T_WPH_NS);
  localparam int ACC_CYC = cyc_min(T_ACC_NS);
  localparam int VPP_CYC = cyc_min(T_VPP_NS);
  localparam int PROG_CYC = cyc_min(T_PROG_US * 1000);
  localparam int RECOV_CYC = cyc_min(T_RECOV_US * 1000);
  localparam int ERASE_CYC = cyc_min(T_ERASE_US * 1000);

  // ----------------------------------------------------------------
  // Command bytes, data values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_SIG = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_VFY = 8'hA0;
  localparam logic [7:0] CMD_PROG = 8'h40;
  localparam logic [7:0] CMD_PROG_VFY = 8'hC0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] PRECOND_BYTE = 8'h00;
  localparam int PROG_TRIES = 25;
  localparam int ERASE_TRIES = 1000;
  localparam int ADDR_W = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_SIG = 3'h1,
    OP_PROG = 3'h2,
    OP_ERASE = 3'h3,
    OP_RESET = 3'h4
  } op_t;

  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } host_cmd_t;

  typedef struct packed {
    logic ok;
    logic [7:0] data;
  } host_rsp_t;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } bus_req_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0] dout;
    logic dout_en_n;
  } flash_pins_t;

endpackage : flash_host_pkg

// file: hdl/flash_bus_cycle.sv
// Single read or write bus cycle on the flash strobe pins.
`timescale 1ns/100ps
module flash_bus_cycle (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic req_valid,
  input wire flash_host_pkg::bus_req_t req,
  output logic req_ready,
  output logic done,
  output logic [7:0] rdata,
  output flash_host_pkg::flash_pins_t pins,
  input wire logic [7:0] dq_in
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    B_IDLE = 5'b00001,
    B_SETUP = 5'b00010,
    B_STROBE = 5'b00100,
    B_HOLD = 5'b01000,
    B_READ = 5'b10000
  } bstate_t;

  localparam flash_host_pkg::flash_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, '0, 8'h00, 1'b1};

  bstate_t state, next_state;
  logic [5:0] cnt, next_cnt;
  logic next_done;
  logic [7:0] next_rdata;
  flash_host_pkg::flash_pins_t next_pins;
  logic [7:0] dq_s1, dq_s2;

  assign req_ready = (state == B_IDLE);

  // Read data arrives from the pins and passes two flip-flops.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // Sequences chip select, strobes and data drive for one cycle.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_done = 1'b0;
    next_rdata = rdata;
    next_pins = pins;
    unique case (state)
      B_IDLE: begin
        if (req_valid) begin
          next_pins.addr = req.addr;
          next_pins.ce_n = 1'b0;
          if (req.wr) begin
            next_pins.dout = req.data;
            next_pins.dout_en_n = 1'b0;
            next_state = B_SETUP;
          end else begin
            next_pins.oe_n = 1'b0;
            next_cnt = 6'(flash_host_pkg::ACC_CYC + flash_host_pkg::SYNC_CYC - 1);
            next_state = B_READ;
          end
        end
      end
      B_SETUP: begin
        next_pins.we_n = 1'b0;
        next_cnt = 6'(flash_host_pkg::WP_CYC - 1);
        next_state = B_STROBE;
      end
      B_STROBE: begin
        if (cnt == 6'h00) begin
          next_pins.we_n = 1'b1;
          next_cnt = 6'(flash_host_pkg::WPH_CYC - 1);
          next_state = B_HOLD;
        end else begin
          next_cnt = cnt - 6'h01;
        end
      end
      B_HOLD: begin
        if (cnt == 6'h00) begin
          next_pins = PINS_IDLE;
          next_done = 1'b1;
          next_state = B_IDLE;
        end else begin
          next_cnt = cnt - 6'h01;
        end
      end
      B_READ: begin
        if (cnt == 6'h00) begin
          next_rdata = dq_s2;
          next_pins = PINS_IDLE;
          next_done = 1'b1;
          next_state = B_IDLE;
        end else begin
          next_cnt = cnt - 6'h01;
        end
      end
    endcase
  end

  // Registers the cycle sequencer.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= B_IDLE;
      cnt <= 6'h00;
      done <= 1'b0;
      rdata <= 8'h00;
      pins <= PINS_IDLE;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      done <= next_done;
      rdata <= next_rdata;
      pins <= next_pins;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_strobe;
    !pins.we_n [*4] ##1 pins.we_n;
  endsequence

  property p_we_pulse;
    @(posedge clk_sys) disable iff (!resetn)
    $fell(pins.we_n) |-> s_strobe;
  endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("Write strobe low time is not four cycles.");

  property p_no_contention;
    @(posedge clk_sys) disable iff (!resetn)
    !pins.dout_en_n |-> pins.oe_n && !pins.ce_n;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("Data driven while output enable is low.");

endmodule : flash_bus_cycle

// file: bench/flash_model.sv
// Behavioural model of the flash memory as seen from its strobe pins.
`timescale 1ns/100ps
module flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value.
  parameter logic [7:0] DEV_CODE = 8'hC3 // Arbitrary value.
) (
  input wire flash_host_pkg::flash_pins_t pins,
  input wire logic vpp_en,
  input wire logic stuck,
  output logic [7:0] dq,
  output logic [7:0] pulses,
  output logic in_read,
  output logic viol
);
  typedef enum logic [2:0] {M_READ, M_SIG, M_PSET, M_ESET, M_PVFY, M_EVFY, M_ABORT} mode_t;
  mode_t mode = M_READ;
  logic [7:0] mem [logic [15:0]];
  logic [15:0] lat_addr = 16'h0000;
  logic [7:0] last = 8'h00;
  logic drive;
  logic pgm = 1'b0;
  realtime t_pulse = 0.0;
  realtime t_wr = -1.0e9;

  // Unwritten bytes read back as erased.
  function automatic logic [7:0] rd(input logic [15:0] a);
    rd = mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : rd

  initial begin
    pulses = 8'h00;
    viol = 1'b0;
  end

  // Command register, latched at the strobe rise while the supply is high.
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && !vpp_en) begin
      viol = 1'b1;
    end else if (!pins.ce_n) begin
      if (pgm && ($realtime - t_pulse < 10000.0)) viol = 1'b1;
      pgm = 1'b0;
      if (mode == M_PSET) begin
        lat_addr = pins.addr;
        if (!stuck) mem[pins.addr] = rd(pins.addr) & pins.dout;
        pulses = pulses + 8'h01;
        pgm = 1'b1;
        t_pulse = $realtime;
        t_wr = $realtime;
        mode = M_READ;
      end else if (mode == M_ESET && pins.dout == 8'h20) begin
        mem.delete();
        t_wr = $realtime;
        mode = M_READ;
      end else if (mode == M_ABORT && pins.dout == 8'hFF) begin
        mode = M_READ;
      end else begin
        case (pins.dout)
          8'h00: mode = M_READ;
          8'h90: mode = M_SIG;
          8'h40: mode = M_PSET;
          8'h20: mode = M_ESET;
          8'hC0: begin
            mode = M_PVFY;
            t_wr = $realtime;
          end
          8'hA0: begin
            mode = M_EVFY;
            lat_addr = pins.addr;
            t_wr = $realtime;
          end
          8'hFF: mode = M_ABORT;
          default: mode = M_READ;
        endcase
      end
    end
  end

  // A read too soon after a program or erase write is flagged.
  always @(negedge pins.oe_n) begin
    if (!pins.ce_n && ($realtime - t_wr < 6000.0)) viol = 1'b1;
  end

  // Data pins: host value, device value, or the inverse of the last value when floating.
  always_comb begin
    drive = !pins.ce_n && !pins.oe_n && pins.we_n;
  end
  always @* begin
    if (!pins.dout_en_n) begin
      dq = pins.dout;
    end else if (drive) begin
      case (mode)
        M_SIG: dq = pins.addr[0] ? DEV_CODE : MAKER_CODE;
        M_PVFY, M_EVFY: dq = rd(lat_addr);
        default: dq = rd(pins.addr);
      endcase
      last = dq;
    end else begin
      dq = ~last;
    end
  end
  assign in_read = (mode == M_READ);
endmodule : flash_model

// file: bench/flash_host_bench.sv
// Self-checking bench of the flash host controller against the flash model.
`timescale 1ns/100ps
module flash_host_bench;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value.
  localparam logic [7:0] DEVICE = 8'hC3; // Arbitrary value.
  logic clk_sys, resetn, cmd_valid, cmd_ready, rsp_valid, vpp_en, stuck, in_read, viol;
  flash_host_pkg::host_cmd_t cmd;
  flash_host_pkg::host_rsp_t rsp, r;
  flash_host_pkg::flash_pins_t pins;
  logic [7:0] dq, pulses, p0;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  flash_host #(.ERASE_PULSE_CYC(50), .PROG_LIMIT(25), .ERASE_LIMIT(3)) flash_host_inst (
    .clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .dq_in(dq), .vpp_en(vpp_en));
  flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEVICE)) flash_model_inst (
    .pins(pins), .vpp_en(vpp_en), .stuck(stuck), .dq(dq), .pulses(pulses),
    .in_read(in_read), .viol(viol));

  // ----------------------------------------------------------------
  // Clock, timeout and closing report
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 100000) begin
      errors++;
      results();
    end
  end
  task automatic results;
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Shared compare and command tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until taken, then waits for the one-cycle answer; the watchdog bounds both.
  task automatic run(input flash_host_pkg::op_t op, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cmd = '{op: op, addr: a, data: d};
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) begin
      @(negedge clk_sys);
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1) begin
      @(negedge clk_sys);
    end
    r = rsp;
  endtask : run

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({pins.ce_n, pins.oe_n, pins.we_n, pins.dout_en_n, vpp_en}, 16'h001E);
    chk(in_read, 16'h0001);
    chk({cmd_ready, rsp_valid}, 16'h0002);
  endtask : t_reset
  task automatic t_read_sig;
    run(flash_host_pkg::OP_READ, 16'h1234, 8'h00);
    chk(r, {7'h00, 1'b1, 8'hFF});
    run(flash_host_pkg::OP_SIG, 16'h0000, 8'h00);
    chk(r, {7'h00, 1'b1, MAKER});
    run(flash_host_pkg::OP_SIG, 16'h0001, 8'h00);
    chk(r, {7'h00, 1'b1, DEVICE});
  endtask : t_read_sig
  task automatic t_prog;
    p0 = pulses;
    run(flash_host_pkg::OP_PROG, 16'h0042, 8'h3C);
    chk(r, {7'h00, 1'b1, 8'h3C});
    chk(pulses - p0, 16'h0001);
    run(flash_host_pkg::OP_PROG, 16'hFFFF, 8'hA5);
    chk(r, {7'h00, 1'b1, 8'hA5});
    run(flash_host_pkg::OP_READ, 16'h0042, 8'h00);
    chk(r, {7'h00, 1'b1, 8'h3C});
    chk(in_read, 16'h0001);
  endtask : t_prog
  task automatic t_prog_fail;
    stuck = 1'b1;
    p0 = pulses;
    run(flash_host_pkg::OP_PROG, 16'h0050, 8'h0F);
    chk(r, {7'h00, 1'b0, 8'hFF});
    chk(pulses - p0, 16'd25);
    stuck = 1'b0;
  endtask : t_prog_fail
  task automatic t_abort;
    run(flash_host_pkg::OP_RESET, 16'h0000, 8'h00);
    chk(r.ok, 16'h0001);
    chk(in_read, 16'h0001);
    chk({vpp_en, viol}, 16'h0000);
  endtask : t_abort
  // Starts an erase, lets two bytes precondition to 00H, then cuts it with a reset in mid-run.
  task automatic t_erase_pre;
    p0 = pulses;
    @(negedge clk_sys);
    cmd = '{op: flash_host_pkg::OP_ERASE, addr: 16'h1234, data: 8'h77};
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    repeat (2000) @(negedge clk_sys);
    chk({cmd_ready, vpp_en, pulses - p0}, 16'h0102);
    resetn = 1'b0;
    @(negedge clk_sys);
    chk({pins.ce_n, pins.oe_n, pins.we_n, pins.dout_en_n, vpp_en, cmd_ready}, 16'h003D);
    resetn = 1'b1;
    @(negedge clk_sys);
    chk({cmd_ready, rsp_valid, vpp_en}, 16'h0004);
    repeat (1000) @(negedge clk_sys);
    run(flash_host_pkg::OP_READ, 16'h0001, 8'h00);
    chk(r, {7'h00, 1'b1, 8'h00});
    chk(viol, 16'h0000);
  endtask : t_erase_pre

  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    stuck = 1'b0;
    repeat (5) @(negedge clk_sys);
    t_reset();
    resetn = 1'b1;
    t_read_sig();
    t_prog();
    t_prog_fail();
    t_abort();
    t_erase_pre();
    results();
  end
endmodule : flash_host_bench
